// *** dsr_top.sv ***
// Our own choices: the placing of the registers and the APB interface to the registers.
module dsr_top
  import dsr_pkg::*;
#(
  parameter int VU_MAX   = 7,
  parameter int BAND_ENT = 256
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // drive events
  input  wire logic        fault_reset,
  // host side
  output logic             attention,
  output dsr_resp_t        resp_word,
  output logic             resp_strobe
);

  logic [15:0] vu_mem   [VU_MAX];
  logic [15:0] band_mem [3*BAND_ENT];

  logic [15:0] std_st, next_std_st, std_prev;
  logic [15:0] ext_st, next_ext_st, ext_prev;
  logic [15:0] opt_st, next_opt_st, opt_prev;
  logic [15:0] trk, next_trk;
  logic [15:0] cfg, next_cfg;
  logic [31:0] caps, next_caps;
  logic [9:0]  bsel, next_bsel;
  dsr_cmd_t    cmd, next_cmd;
  dsr_resp_t   next_resp_word;
  logic        inv, next_inv;
  logic        next_attention, next_resp_strobe;
  logic        next_pready, next_pslverr;
  logic [31:0] next_prdata;
  logic        wr, rd, hit, att_set;
  dsr_cmd_t    wc;
  logic [15:0] rdata;
  logic        rinv;
  logic [2:0]  vu_cnt;
  logic [7:0]  bands;
  logic [8:0]  bent;
  logic [1:0]  media;

  assign wr = psel & penable & pready & pwrite;
  assign rd = psel & penable & ~pready & ~pwrite;
  assign wc = dsr_cmd_t'(pwdata[15:0]);
  assign vu_cnt = caps[CAPS_VU_LSB +: 3];

  // response selection for a written command
  always_comb begin
    rdata = 16'h0000;
    rinv  = 1'b0;
    media = 2'(wc.modf - MOD_BAND_RO);
    bands = caps[CAPS_BAND_LSB + 8*media +: 8];
    bent  = {bands, 1'b0};
    if (wc.func == FN_CONFIG) begin
      rdata = {cfg[15:3], vu_cnt};
    end else if (wc.func != FN_STATUS) begin
      rinv = 1'b1;
    end else if (wc.modf == MOD_STD) begin
      if (wc.sub == SUB_STD) begin
        rdata = std_st;
      end else if (wc.sub == SUB_EXT) begin
        rdata = ext_st;
      end else begin
        rinv = 1'b1;
      end
    end else if (wc.modf <= MOD_VU_LAST) begin
      if (3'(wc.modf - MOD_VU_FIRST) < vu_cnt) begin
        rdata = vu_mem[3'(wc.modf - MOD_VU_FIRST)];
      end else begin
        rinv = 1'b1;
      end
    end else if (wc.modf == MOD_OPT) begin
      rdata = opt_st;
    end else if (wc.modf == MOD_TRK) begin
      if (caps[CAPS_DIST]) begin
        rinv = 1'b1;
      end else begin
        rdata = trk;
      end
    end else if (wc.modf >= MOD_BAND_RO && wc.modf <= MOD_BAND_ER) begin
      if ({1'b0, wc.sub} < bent) begin
        rdata = band_mem[10'({media, wc.sub})];
      end else begin
        rinv = 1'b1;
      end
    end else begin
      rinv = 1'b1;
    end
  end

  // attention on set edges of fault bits and sync loss
  always_comb begin
    att_set = |(std_st & ~std_prev & STD_ATT_MASK)
            | (std_prev[STD_SYNC] & ~std_st[STD_SYNC])
            | |(ext_st & ~ext_prev & EXT_MASK)
            | |(opt_st & ~opt_prev & OPT_ATT_MASK);
  end

  // register file and command next state
  always_comb begin
    next_std_st      = std_st;
    next_ext_st      = ext_st;
    next_opt_st      = opt_st;
    next_trk         = trk;
    next_cfg         = cfg;
    next_caps        = caps;
    next_bsel        = bsel;
    next_cmd         = cmd;
    next_inv         = inv;
    next_resp_word   = resp_word;
    next_resp_strobe = 1'b0;
    next_attention   = attention;
    if (wr) begin
      case (paddr)
        ADR_STD:  next_std_st = pwdata[15:0] & STD_MASK;
        ADR_EXT:  next_ext_st = pwdata[15:0] & EXT_MASK;
        ADR_OPT:  next_opt_st = pwdata[15:0] & OPT_MASK;
        ADR_TRK:  next_trk    = pwdata[15:0];
        ADR_CFG:  next_cfg    = pwdata[15:0];
        ADR_CAPS: next_caps   = pwdata;
        ADR_BSEL: next_bsel   = pwdata[9:0];
        ADR_BDAT: next_bsel   = 10'(bsel + 10'h001);
        ADR_CMD: begin
          next_cmd         = wc;
          next_inv         = rinv;
          next_resp_word   = dsr_pack(rdata);
          next_resp_strobe = 1'b1;
          if (rinv) begin
            next_std_st[STD_INVALID] = 1'b1;
          end
          if (wc.func == FN_STATUS && wc.modf == MOD_STD) begin
            next_attention = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (fault_reset) begin
      next_std_st[STD_POWER_ON] = 1'b1;
    end
    if (att_set) begin
      next_attention = 1'b1;
    end
  end

  // apb access phase with one wait state
  always_comb begin
    next_pready  = psel & penable & ~pready;
    next_pslverr = 1'b0;
    next_prdata  = 32'h0000_0000;
    hit          = 1'b1;
    case (paddr)
      ADR_CMD:  next_prdata = {16'h0000, cmd};
      ADR_RESP: next_prdata = {13'h0000, attention, inv, resp_word};
      ADR_STD:  next_prdata = {16'h0000, std_st};
      ADR_EXT:  next_prdata = {16'h0000, ext_st};
      ADR_OPT:  next_prdata = {16'h0000, opt_st};
      ADR_TRK:  next_prdata = {16'h0000, trk};
      ADR_CFG:  next_prdata = {16'h0000, cfg};
      ADR_CAPS: next_prdata = caps;
      ADR_BSEL: next_prdata = {22'h000000, bsel};
      ADR_BDAT: next_prdata = {16'h0000, band_mem[bsel]};
      default: begin
        hit = (paddr >= ADR_VU0) && (paddr < 8'(ADR_VU0 + 4*VU_MAX)) && (paddr[1:0] == 2'b00);
        if (hit) begin
          next_prdata = {16'h0000, vu_mem[3'((paddr - ADR_VU0) >> 2)]};
        end
      end
    endcase
    if (!rd) begin
      next_prdata = 32'h0000_0000;
    end
    if (psel && penable && !pready) begin
      next_pslverr = ~hit;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      std_st      <= STD_RST;
      std_prev    <= 16'h0000;
      ext_st      <= 16'h0000;
      ext_prev    <= 16'h0000;
      opt_st      <= 16'h0000;
      opt_prev    <= 16'h0000;
      trk         <= 16'h0000;
      cfg         <= 16'h0000;
      caps        <= 32'h0000_0000;
      bsel        <= 10'h000;
      cmd         <= '0;
      inv         <= 1'b0;
      resp_word   <= '0;
      resp_strobe <= 1'b0;
      attention   <= 1'b0;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      prdata      <= 32'h0000_0000;
    end else begin
      std_st      <= next_std_st;
      std_prev    <= std_st;
      ext_st      <= next_ext_st;
      ext_prev    <= ext_st;
      opt_st      <= next_opt_st;
      opt_prev    <= opt_st;
      trk         <= next_trk;
      cfg         <= next_cfg;
      caps        <= next_caps;
      bsel        <= next_bsel;
      cmd         <= next_cmd;
      inv         <= next_inv;
      resp_word   <= next_resp_word;
      resp_strobe <= next_resp_strobe;
      attention   <= next_attention;
      pready      <= next_pready;
      pslverr     <= next_pslverr;
      prdata      <= next_prdata;
    end
  end

  // table memories written from the bus
  always_ff @(posedge clk) begin
    if (wr && paddr == ADR_BDAT) begin
      band_mem[bsel] <= pwdata[15:0];
    end
    if (wr && paddr >= ADR_VU0 && paddr < 8'(ADR_VU0 + 4*VU_MAX)) begin
      vu_mem[3'((paddr - ADR_VU0) >> 2)] <= pwdata[15:0];
    end
  end

endmodule : dsr_top

// *** dsr_pkg.sv ***
package dsr_pkg;
  localparam logic [7:0]  ADR_CMD        = 8'h00;
  localparam logic [7:0]  ADR_RESP       = 8'h04;
  localparam logic [7:0]  ADR_STD        = 8'h08;
  localparam logic [7:0]  ADR_EXT        = 8'h0c;
  localparam logic [7:0]  ADR_OPT        = 8'h10;
  localparam logic [7:0]  ADR_TRK        = 8'h14;
  localparam logic [7:0]  ADR_CFG        = 8'h18;
  localparam logic [7:0]  ADR_CAPS       = 8'h1c;
  localparam logic [7:0]  ADR_BSEL       = 8'h20;
  localparam logic [7:0]  ADR_BDAT       = 8'h24;
  localparam logic [7:0]  ADR_VU0        = 8'h40;
  localparam logic [3:0]  FN_STATUS      = 4'h2;
  localparam logic [3:0]  FN_CONFIG      = 4'h3;
  localparam logic [3:0]  MOD_STD        = 4'h0;
  localparam logic [3:0]  MOD_VU_FIRST   = 4'h1;
  localparam logic [3:0]  MOD_VU_LAST    = 4'h7;
  localparam logic [3:0]  MOD_OPT        = 4'h9;
  localparam logic [3:0]  MOD_TRK        = 4'ha;
  localparam logic [3:0]  MOD_BAND_RO    = 4'hb;
  localparam logic [3:0]  MOD_BAND_ER    = 4'hd;
  localparam logic [7:0]  SUB_STD        = 8'h00;
  localparam logic [7:0]  SUB_EXT        = 8'h01;
  localparam int          STD_SYNC       = 11;
  localparam int          STD_POWER_ON   = 7;
  localparam int          STD_INVALID    = 4;
  localparam logic [15:0] STD_MASK       = 16'h7fff;
  localparam logic [15:0] EXT_MASK       = 16'h0800;
  localparam logic [15:0] OPT_MASK       = 16'hfffe;
  localparam logic [15:0] STD_ATT_MASK   = 16'h07ff;
  localparam logic [15:0] OPT_ATT_MASK   = 16'hfff8;
  localparam logic [15:0] STD_RST        = 16'h0080;
  localparam int          CAPS_VU_LSB    = 0;
  localparam int          CAPS_DIST      = 3;
  localparam int          CAPS_BAND_LSB  = 8;
  localparam int          RESP_INV       = 17;
  localparam int          RESP_ATT       = 18;

  typedef struct packed {
    logic [3:0] func;
    logic [3:0] modf;
    logic [7:0] sub;
  } dsr_cmd_t;

  typedef struct packed {
    logic        par;
    logic [15:0] data;
  } dsr_resp_t;

  function automatic dsr_resp_t dsr_pack(input logic [15:0] d);
    dsr_resp_t r;
    r.data = d;
    r.par  = ~^d;
    return r;
  endfunction : dsr_pack
endpackage : dsr_pkg

// *** dsr_top_checker.sv ***
module dsr_top_checker
  import dsr_pkg::*;
#(
  parameter int VU_MAX   = 7,
  parameter int BAND_ENT = 256
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // drive events and host side
  input wire logic        fault_reset,
  input wire logic        attention,
  input wire dsr_resp_t   resp_word,
  input wire logic        resp_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence cmd_wr_s;
    psel && penable && pready && pwrite && paddr == ADR_CMD;
  endsequence
  sequence bad_mod_s;
    psel && penable && pready && pwrite && paddr == ADR_CMD && pwdata[15:12] == FN_STATUS
      && pwdata[11:8] inside {4'h8, 4'he, 4'hf};
  endsequence
  sequence clear_s;
    psel && penable && pready && pwrite && paddr == ADR_CMD && pwdata[15:8] == 8'h20 && pwdata[7:1] == 7'h00;
  endsequence
  chk_odd_parity: assert property (resp_strobe |-> ^resp_word)
    else $error("response parity not odd");
  chk_cmd_answer: assert property (cmd_wr_s |-> ##[1:2] resp_strobe)
    else $error("no response after command");
  chk_bad_invalid: assert property (bad_mod_s |-> ##[1:2] (resp_strobe && resp_word == 17'h10000))
    else $error("reserved modifier not refused");
  chk_power_att: assert property ($fell(sys_rst) |-> ##[1:3] attention)
    else $error("no attention after power on");
  chk_att_clear: assert property (clear_s |-> ##[1:3] !attention)
    else $error("attention not cleared by status request");
  chk_ready_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("ready not one cycle after access");
  chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error reply carries data");
  chk_strobe_pulse: assert property (resp_strobe |=> !resp_strobe)
    else $error("strobe longer than one cycle");
endmodule : dsr_top_checker

bind dsr_top dsr_top_checker #(.VU_MAX(VU_MAX), .BAND_ENT(BAND_ENT)) chk_u (.clk(clk), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .fault_reset(fault_reset), .attention(attention),
  .resp_word(resp_word), .resp_strobe(resp_strobe));

// *** dsr_host_model.sv ***
module dsr_host_model
  import dsr_pkg::*;
(
  // clock and reset
  input  wire logic      clk,
  input  wire logic      sys_rst,
  // drive side
  input  wire dsr_resp_t resp_word,
  input  wire logic      resp_strobe,
  // captured replies
  output dsr_resp_t      last_resp,
  output int             n_resp,
  output logic           power_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  // takes each reply; a power-on word tells the host to reconfigure
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      last_resp  <= '0;
      n_resp     <= 0;
      power_seen <= 1'b0;
    end else if (resp_strobe) begin
      last_resp  <= resp_word;
      n_resp     <= n_resp + 1;
      power_seen <= power_seen | resp_word.data[STD_POWER_ON];
    end
  end
endmodule : dsr_host_model

// *** test_drive_status_responder.sv ***
`define CHK(nm, e, g) begin if ((g) !== (e)) begin $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
  n_mismatch++; end n_compared++; end
module test_drive_status_responder
  import dsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, fault_reset, attention, resp_strobe;
  logic        power_seen;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  dsr_resp_t   resp_word, last_resp;
  int          n_resp, n_mismatch, n_compared;
  dsr_top dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .fault_reset(fault_reset),
    .attention(attention), .resp_word(resp_word), .resp_strobe(resp_strobe));
  dsr_host_model host_u (.clk(clk), .sys_rst(sys_rst), .resp_word(resp_word),
    .resp_strobe(resp_strobe), .last_resp(last_resp), .n_resp(n_resp), .power_seen(power_seen));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic conclude();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    `CHK("read", x, q)
  endtask : rd
  task automatic wait_att(input logic x);
    repeat (4) @(posedge clk);
    `CHK("attention", x, attention)
  endtask : wait_att
  task automatic cmd(input logic [15:0] c, input logic [15:0] x, input logic inv);
    int          k;
    logic [31:0] q;
    logic        e;
    k = n_resp;
    apb(1'b1, ADR_CMD, {16'h0, c}, q, e);
    repeat (3) @(posedge clk);
    `CHK("count", k + 1, n_resp)
    `CHK("reply", {~^x, x}, last_resp)
    apb(1'b0, ADR_RESP, 32'h0, q, e);
    `CHK("invalid", inv, q[RESP_INV])
  endtask : cmd
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
  initial begin
    logic [31:0] q;
    logic        e;
    sys_rst = 1'b1;
    {psel, penable, pwrite, fault_reset, paddr, pwdata} = '0;
    n_mismatch = 0;
    n_compared = 0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    wait_att(1'b1);
    rd(ADR_STD, 32'h80);
    wr(ADR_CAPS, 32'h0101_0103);
    wr(ADR_CFG, 32'habcd);
    wr(ADR_STD, 32'h0880);
    cmd(16'h2000, 16'h0880, 1'b0);
    `CHK("power seen", 1'b1, power_seen)
    wr(ADR_STD, 32'h0080);
    wait_att(1'b1);
    cmd(16'h2000, 16'h0080, 1'b0);
    wr(ADR_TRK, 32'h1234);
    wait_att(1'b0);
    cmd(16'h2a00, 16'h1234, 1'b0);
    wr(ADR_EXT, 32'hffff);
    wait_att(1'b1);
    cmd(16'h2001, 16'h0800, 1'b0);
    cmd(16'h2000, 16'h0080, 1'b0);
    wr(ADR_OPT, 32'h0008);
    wait_att(1'b1);
    wr(ADR_OPT, 32'hffff);
    cmd(16'h2900, 16'hfffe, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(ADR_OPT, 32'(16'h8000 | (i << 1)));
      cmd(16'h2900, 16'(16'h8000 | (i << 1)), 1'b0);
    end
    for (int i = 0; i < 3; i++) begin
      wr(8'(ADR_VU0 + 4 * i), 32'(16'h1110 + i));
    end
    for (int i = 0; i < 3; i++) begin
      cmd({4'h2, 4'(i + 1), 8'h0}, 16'(16'h1110 + i), 1'b0);
    end
    cmd(16'h2400, 16'h0, 1'b1);
    wr(ADR_CAPS, 32'h0101_010b);
    cmd(16'h2a00, 16'h0, 1'b1);
    for (int m = 0; m < 3; m++) begin
      wr(ADR_BSEL, 32'(m << 8));
      wr(ADR_BDAT, 32'(16'h0100 + m));
      wr(ADR_BDAT, 32'(16'h0200 + m));
      cmd({4'h2, 4'(11 + m), 8'h0}, 16'(16'h0100 + m), 1'b0);
      cmd({4'h2, 4'(11 + m), 8'h1}, 16'(16'h0200 + m), 1'b0);
      cmd({4'h2, 4'(11 + m), 8'h2}, 16'h0, 1'b1);
    end
    cmd(16'h2800, 16'h0, 1'b1);
    cmd(16'h2e00, 16'h0, 1'b1);
    cmd(16'h2f00, 16'h0, 1'b1);
    cmd(16'h2002, 16'h0, 1'b1);
    cmd(16'h0000, 16'h0, 1'b1);
    cmd(16'h3000, 16'habcb, 1'b0);
    rd(ADR_STD, 32'h0090);
    wr(ADR_STD, 32'h0);
    cmd(16'h2000, 16'h0, 1'b0);
    wr(ADR_STD, 32'hf000);
    wait_att(1'b0);
    @(posedge clk);
    fault_reset <= 1'b1;
    @(posedge clk);
    fault_reset <= 1'b0;
    wait_att(1'b1);
    rd(ADR_STD, 32'h7080);
    apb(1'b0, 8'h30, 32'h0, q, e);
    `CHK("error", 1'b1, e)
    `CHK("error data", 32'h0, q)
    conclude();
  end
endmodule : test_drive_status_responder
